// File: design/mffc_pkg.sv
// Purpose: shared constants for the motor field and fault configuration bank
// Assumes: 32-bit APB register access, one clock at 40 MHz
// Notes:   percentages are in tenths of a percent for the brake limit, whole percent elsewhere

package mffc_pkg;

	// ---------------------------------------------------------------
	// register byte offsets
	// ---------------------------------------------------------------
	localparam logic [7:0]  MFFC_OFS_CLOSED_LOOP_TWO = 8'h48;
	localparam logic [7:0]  MFFC_OFS_FLUX_TORQUE     = 8'h4C;
	localparam logic [7:0]  MFFC_OFS_LOCK_FAULT      = 8'h50;
	localparam logic [7:0]  MFFC_OFS_IRQ_STATUS      = 8'h60;
	localparam logic [7:0]  MFFC_OFS_IRQ_ENABLE      = 8'h64;
	localparam logic [7:0]  MFFC_OFS_IRQ_CLEAR       = 8'h68;

	// ---------------------------------------------------------------
	// reset values and masks
	// ---------------------------------------------------------------
	localparam logic [31:0] MFFC_RST_CLOSED_LOOP_TWO = 32'h0000_0000;
	localparam logic [31:0] MFFC_RST_FLUX_TORQUE     = 32'h0000_0000;
	localparam logic [31:0] MFFC_RST_LOCK_FAULT      = 32'h0000_0000;
	localparam logic [31:0] MFFC_FLUX_TORQUE_MASK    = 32'h0000_007F;

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int          MFFC_BRAKE_LSB           = 19;
	localparam int          MFFC_TPA_BIT             = 6;
	localparam int          MFFC_FW_REF_LSB          = 4;
	localparam int          MFFC_FW_CAP_LSB          = 1;
	localparam int          MFFC_FW_EN_BIT           = 0;
	localparam int          MFFC_RETRY_LSB           = 2;
	localparam int          MFFC_MODE_LSB            = 0;

	// interrupt status bits
	localparam int          MFFC_IRQ_W               = 3;
	localparam int          MFFC_ST_LOCK_FAULT       = 0;
	localparam int          MFFC_ST_LOCK_REPORT      = 1;
	localparam int          MFFC_ST_RETRY_DONE       = 2;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int          MFFC_CLK_HZ              = 40_000_000;
	localparam int          MFFC_TICK_MS             = 1;
	localparam int          MFFC_TICK_CYCLES         = MFFC_CLK_HZ / 1000 * MFFC_TICK_MS;
	localparam logic [13:0] MFFC_RETRY_MS_C0         = 14'd100;
	localparam logic [13:0] MFFC_RETRY_MS_C1         = 14'd500;
	localparam logic [13:0] MFFC_RETRY_MS_C2         = 14'd1000;
	localparam logic [13:0] MFFC_RETRY_STEP_MS       = 14'd1000;

	typedef enum logic [1:0] {
		MFFC_LOCK_LATCH,
		MFFC_LOCK_RETRY,
		MFFC_LOCK_REPORT,
		MFFC_LOCK_OFF
	} mffc_lock_mode_t;

endpackage : mffc_pkg

// File: design/mffc_regs.sv
// Purpose: APB register bank for brake limit, field control and lock fault setup
// Assumes: lock_detect is a one-cycle pulse from the control algorithm
// Notes:   zero-wait APB slave, read data loaded in the setup cycle
// Function
// - five-bit brake current code in bits 23..19 of closed_loop_setup_two, reset 0.
// - field-control bit 6 enables torque-per-amp control, reset 0.
// - field-control bits 5..4 pick modulation target 70, 80, 90, 95%.
// - bits 3..1 cap field weakening current: 0 circular only, 80..20%.
// - bit 0 enables field weakening; bits 31..7 read as zero.
// - lock fault bits 5..2 pick retry 100ms, 500ms, 1s, then 2..14s.
// - lock mode 0 latches a fault and drives fault_out_low active.
// - lock mode 1 clears the lock fault after the retry interval.
// - lock mode 2 only reports a lock, never stops the motor.
// - lock mode 3 disables lock detection entirely.
//
// Our own choice: the APB slave port.

`timescale 1ns/100ps
`default_nettype none

module mffc_regs
	import mffc_pkg::*;
#(
	parameter int CYCLES_PER_MS = MFFC_TICK_CYCLES
)
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic             pslverr,
	output logic [31:0]      prdata,
	// motor control side
	input  wire logic        lock_detect,
	output logic [9:0]       brake_current_limit,
	output logic             torque_per_amp_enable,
	output logic             field_weaken_enable,
	output logic [6:0]       mod_index_target_pct,
	output logic [6:0]       field_weaken_current_cap,
	output logic             motor_stop,
	output logic             fault_out_low,
	output logic             irq
);

	// ---------------------------------------------------------------
	// decoders
	// ---------------------------------------------------------------
	function automatic logic [9:0] brake_tenths(input logic [4:0] code);
		logic [9:0] c;
		c = {5'h00, code};
		if (code <= 5'h04)
			brake_tenths = 10'd75 + 10'(c * 10'd5);
		else if (code <= 5'h0D)
			brake_tenths = 10'd100 + 10'((c - 10'd5) * 10'd10);
		else if (code == 5'h0E)
			brake_tenths = 10'd200;
		else if (code <= 5'h12)
			brake_tenths = 10'd225 + 10'((c - 10'd15) * 10'd25);
		else if (code <= 5'h18)
			brake_tenths = 10'd350 + 10'((c - 10'd19) * 10'd50);
		else if (code == 5'h19)
			brake_tenths = 10'd700;
		else
			brake_tenths = 10'd750 + 10'((c - 10'd26) * 10'd50);
	endfunction : brake_tenths

	function automatic logic [13:0] retry_ms(input logic [3:0] code);
		unique case (code)
			4'h0:    retry_ms = MFFC_RETRY_MS_C0;
			4'h1:    retry_ms = MFFC_RETRY_MS_C1;
			4'h2:    retry_ms = MFFC_RETRY_MS_C2;
			default: retry_ms = 14'(({10'h000, code} - 14'd1) * MFFC_RETRY_STEP_MS);
		endcase
	endfunction : retry_ms

	// ---------------------------------------------------------------
	// storage
	// ---------------------------------------------------------------
	logic [31:0]            closed_loop_setup_two;
	logic [31:0]            flux_and_torque_control;
	logic [31:0]            lock_fault_setup;
	logic [MFFC_IRQ_W-1:0]  irq_status;
	logic [MFFC_IRQ_W-1:0]  irq_enable;
	logic [15:0]            ms_div;
	logic [13:0]            ms_count;

	logic                   setup_phase;
	logic                   wr_access;
	logic                   mapped;
	logic                   wr_clear;
	logic [MFFC_IRQ_W-1:0]  clear_bits;
	mffc_lock_mode_t        lock_response_mode;
	logic [3:0]             lock_retry_interval;
	logic [13:0]            retry_limit_ms;
	logic                   lock_fault;
	logic                   lock_set;
	logic                   report_set;
	logic                   retry_active;
	logic                   auto_clear;
	logic                   ms_tick;

	assign setup_phase         = psel && !penable;
	assign wr_access           = psel && penable && pwrite;
	assign lock_response_mode  = mffc_lock_mode_t'(lock_fault_setup[MFFC_MODE_LSB +: 2]);
	assign lock_retry_interval = lock_fault_setup[MFFC_RETRY_LSB +: 4];
	assign retry_limit_ms      = retry_ms(lock_retry_interval);
	assign lock_fault          = irq_status[MFFC_ST_LOCK_FAULT];

	always_comb
	begin
		unique case (paddr)
			MFFC_OFS_CLOSED_LOOP_TWO,
			MFFC_OFS_FLUX_TORQUE,
			MFFC_OFS_LOCK_FAULT,
			MFFC_OFS_IRQ_STATUS,
			MFFC_OFS_IRQ_ENABLE,
			MFFC_OFS_IRQ_CLEAR: mapped = 1'b1;
			default:            mapped = 1'b0;
		endcase
	end

	// ---------------------------------------------------------------
	// apb handshake
	// ---------------------------------------------------------------
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			prdata <= 32'h0000_0000;
		else if (setup_phase && !pwrite)
		begin
			unique case (paddr)
				MFFC_OFS_CLOSED_LOOP_TWO: prdata <= closed_loop_setup_two;
				MFFC_OFS_FLUX_TORQUE:     prdata <= flux_and_torque_control & MFFC_FLUX_TORQUE_MASK;
				MFFC_OFS_LOCK_FAULT:      prdata <= lock_fault_setup;
				MFFC_OFS_IRQ_STATUS:      prdata <= {{(32-MFFC_IRQ_W){1'b0}}, irq_status};
				MFFC_OFS_IRQ_ENABLE:      prdata <= {{(32-MFFC_IRQ_W){1'b0}}, irq_enable};
				default:                  prdata <= 32'h0000_0000;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// configuration registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			closed_loop_setup_two   <= MFFC_RST_CLOSED_LOOP_TWO;
			flux_and_torque_control <= MFFC_RST_FLUX_TORQUE;
			lock_fault_setup        <= MFFC_RST_LOCK_FAULT;
			irq_enable              <= '0;
		end
		else if (wr_access)
		begin
			if (paddr == MFFC_OFS_CLOSED_LOOP_TWO)
				closed_loop_setup_two   <= pwdata;
			if (paddr == MFFC_OFS_FLUX_TORQUE)
				flux_and_torque_control <= pwdata & MFFC_FLUX_TORQUE_MASK;
			if (paddr == MFFC_OFS_LOCK_FAULT)
				lock_fault_setup        <= pwdata;
			if (paddr == MFFC_OFS_IRQ_ENABLE)
				irq_enable              <= pwdata[MFFC_IRQ_W-1:0];
		end
	end

	// ---------------------------------------------------------------
	// decoded control outputs
	// ---------------------------------------------------------------
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			brake_current_limit      <= 10'd75;
			torque_per_amp_enable    <= 1'b0;
			field_weaken_enable      <= 1'b0;
			mod_index_target_pct     <= 7'd70;
			field_weaken_current_cap <= 7'd0;
		end
		else
		begin
			brake_current_limit   <= brake_tenths(closed_loop_setup_two[MFFC_BRAKE_LSB +: 5]);
			torque_per_amp_enable <= flux_and_torque_control[MFFC_TPA_BIT];
			field_weaken_enable   <= flux_and_torque_control[MFFC_FW_EN_BIT];
			unique case (flux_and_torque_control[MFFC_FW_REF_LSB +: 2])
				2'd0: mod_index_target_pct <= 7'd70;
				2'd1: mod_index_target_pct <= 7'd80;
				2'd2: mod_index_target_pct <= 7'd90;
				2'd3: mod_index_target_pct <= 7'd95;
			endcase
			// zero means only the circular limit applies
			if (flux_and_torque_control[MFFC_FW_CAP_LSB +: 3] == 3'd0)
				field_weaken_current_cap <= 7'd0;
			else
				field_weaken_current_cap <= 7'(7'd90 - 7'd10 * {4'h0, flux_and_torque_control[MFFC_FW_CAP_LSB +: 3]});
		end
	end

	// ---------------------------------------------------------------
	// lock handling
	// ---------------------------------------------------------------
	// mode 3 appears in neither set term, so detection is off there
	assign lock_set     = lock_detect && (lock_response_mode == MFFC_LOCK_LATCH
	                      || lock_response_mode == MFFC_LOCK_RETRY);
	assign report_set   = lock_detect && lock_response_mode == MFFC_LOCK_REPORT;
	assign retry_active = lock_fault && lock_response_mode == MFFC_LOCK_RETRY;
	assign ms_tick      = ms_div == 16'(CYCLES_PER_MS - 1);
	assign auto_clear   = retry_active && ms_count >= retry_limit_ms && !lock_detect;

	// retry timer restarts on each new lock
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			ms_div   <= 16'h0000;
			ms_count <= 14'h0000;
		end
		else if (!retry_active || lock_detect || auto_clear)
		begin
			ms_div   <= 16'h0000;
			ms_count <= 14'h0000;
		end
		else if (ms_tick)
		begin
			ms_div   <= 16'h0000;
			ms_count <= ms_count + 14'd1;
		end
		else
			ms_div   <= ms_div + 16'd1;
	end

	// ---------------------------------------------------------------
	// sticky status, set beats clear
	// ---------------------------------------------------------------
	assign wr_clear   = wr_access && paddr == MFFC_OFS_IRQ_CLEAR;
	assign clear_bits = wr_clear ? pwdata[MFFC_IRQ_W-1:0] : '0;

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			irq_status <= '0;
		else
		begin
			if (lock_set)
				irq_status[MFFC_ST_LOCK_FAULT] <= 1'b1;
			else if (auto_clear || clear_bits[MFFC_ST_LOCK_FAULT])
				irq_status[MFFC_ST_LOCK_FAULT] <= 1'b0;
			if (report_set)
				irq_status[MFFC_ST_LOCK_REPORT] <= 1'b1;
			else if (clear_bits[MFFC_ST_LOCK_REPORT])
				irq_status[MFFC_ST_LOCK_REPORT] <= 1'b0;
			if (auto_clear)
				irq_status[MFFC_ST_RETRY_DONE] <= 1'b1;
			else if (clear_bits[MFFC_ST_RETRY_DONE])
				irq_status[MFFC_ST_RETRY_DONE] <= 1'b0;
		end
	end

	assign motor_stop    = lock_fault;
	assign fault_out_low = !lock_fault;
	assign irq           = |(irq_status & irq_enable);

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking chk_clk @(posedge clk); endclocking
	default disable iff (reset);

	chk_brake_low_end: assert property (
		closed_loop_setup_two[23:19] == 5'h04 |=> brake_current_limit == 10'd95)
		else $error("brake code 4 not 9.5 percent");

	chk_brake_high_end: assert property (
		closed_loop_setup_two[23:19] == 5'h19 || closed_loop_setup_two[23:19] == 5'h1F
		|=> brake_current_limit == ($past(closed_loop_setup_two[23:19]) == 5'h19 ? 10'd700 : 10'd1000))
		else $error("brake code 19h or 1Fh decoded wrong");

	chk_field_reserved: assert property (
		setup_phase && !pwrite && paddr == MFFC_OFS_FLUX_TORQUE |=> prdata[31:7] == 25'h0)
		else $error("reserved field bits read nonzero");

	chk_tpa_write: assert property (
		wr_access && paddr == MFFC_OFS_FLUX_TORQUE ##1 1'b1 |=> torque_per_amp_enable == $past(pwdata[6], 2))
		else $error("torque per amp enable not following write");

	chk_cap_decode: assert property (
		flux_and_torque_control[3:1] == 3'd7 |=> field_weaken_current_cap == 7'd20)
		else $error("current cap code 7 not 20 percent");

	chk_latch_fault: assert property (
		lock_detect && lock_response_mode == MFFC_LOCK_LATCH |=> !fault_out_low && motor_stop)
		else $error("latched lock did not assert fault pin");

	chk_latch_hold: assert property (
		lock_fault && lock_response_mode == MFFC_LOCK_LATCH && !clear_bits[0] |=> lock_fault)
		else $error("latched lock fault dropped without clear");

	chk_retry_early: assert property (
		retry_active && ms_count < retry_limit_ms && !clear_bits[MFFC_ST_LOCK_FAULT] |=> lock_fault)
		else $error("lock fault cleared before retry time");

	chk_retry_clear: assert property (
		auto_clear && !lock_detect |=> !lock_fault && irq_status[MFFC_ST_RETRY_DONE])
		else $error("lock fault not cleared at retry time");

	chk_report_only: assert property (
		report_set && !lock_fault |=> irq_status[1] && !motor_stop)
		else $error("report mode stopped motor or missed report");

	chk_mode_off: assert property (
		lock_detect && lock_response_mode == MFFC_LOCK_OFF && !wr_clear |=> $stable(irq_status))
		else $error("disabled lock detection changed status");

	chk_fw_write: assert property (
		wr_access && paddr == MFFC_OFS_FLUX_TORQUE ##1 1'b1 |=> field_weaken_enable == $past(pwdata[0], 2))
		else $error("field weaken enable not following write");

	chk_clear_write: assert property (
		clear_bits[MFFC_ST_LOCK_FAULT] && !lock_set |=> !lock_fault)
		else $error("lock fault not cleared by software");

	chk_retry_decode: assert property (
		lock_retry_interval == 4'h3 |-> retry_limit_ms == 14'd2000)
		else $error("retry code 3 not two seconds");

	cov_latch: cover property (lock_set && lock_response_mode == MFFC_LOCK_LATCH);
	cov_auto_clear: cover property (auto_clear);
	cov_report: cover property (report_set);
	cov_bad_addr: cover property (pslverr);
	cov_mode_off: cover property (lock_detect && lock_response_mode == MFFC_LOCK_OFF);

endmodule : mffc_regs

`default_nettype wire

// File: verification/mffc_stage_model.sv
// Purpose: power stage stand-in facing the motor control side of the bank
// Assumes: one clock; the bench asks for a lock pulse by holding fire one cycle
// Notes:   flags any cycle where the stop level and the fault pin disagree

`timescale 1ns/100ps
`default_nettype none

module mffc_stage_model
(
	// clock and reset
	input  wire logic clk,
	input  wire logic reset,
	// bench request
	input  wire logic fire,
	// block side
	input  wire logic motor_stop,
	input  wire logic fault_out_low,
	output logic      lock_detect,
	output logic      stop_seen,
	output logic      pin_clash
);
	// one-cycle lock pulse, stop and pin tracking
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			lock_detect <= 1'b0;
			stop_seen   <= 1'b0;
			pin_clash   <= 1'b0;
		end
		else
		begin
			lock_detect <= fire;
			stop_seen   <= stop_seen | (motor_stop === 1'b1);
			pin_clash   <= pin_clash | (motor_stop === fault_out_low);
		end
	end
endmodule : mffc_stage_model

`default_nettype wire

// File: verification/mffc_regs_bench.sv
// Purpose: self-checking bench for the field and lock fault register bank
// Assumes: CYCLES_PER_MS set to 4 so retry times stay short
// Notes:   expected values come from the decode tables below

`timescale 1ns/100ps
`default_nettype none

module mffc_regs_bench;
	import mffc_pkg::*;
	localparam int CPM = 4;
	logic        clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fire = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic        pready, pslverr, lock_detect, tpa_en, fw_en, motor_stop, fault_out_low, irq;
	logic        stop_seen, pin_clash, err;
	logic [31:0] prdata, rd, v;
	logic [9:0]  brake;
	logic [6:0]  ref_pct, cap_pct;
	logic [2:0]  k;
	int          bad_count = 0;
	int          num_checks = 0;
	int          brake_tab [32] = '{75, 80, 85, 90, 95, 100, 110, 120, 130, 140, 150, 160, 170, 180, 200, 225,
		250, 275, 300, 350, 400, 450, 500, 550, 600, 700, 750, 800, 850, 900, 950, 1000};
	int          ref_tab [4] = '{70, 80, 90, 95};
	int          cap_tab [8] = '{0, 80, 70, 60, 50, 40, 30, 20};
	int          retry_ms [4] = '{100, 500, 1000, 2000};

	always #12.5 clk = ~clk;

	mffc_regs #(.CYCLES_PER_MS(CPM)) mffc_regs_inst (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
		.lock_detect(lock_detect), .brake_current_limit(brake), .torque_per_amp_enable(tpa_en),
		.field_weaken_enable(fw_en), .mod_index_target_pct(ref_pct), .field_weaken_current_cap(cap_pct),
		.motor_stop(motor_stop), .fault_out_low(fault_out_low), .irq(irq));

	mffc_stage_model mffc_stage_model_inst (.clk(clk), .reset(reset), .fire(fire), .motor_stop(motor_stop),
		.fault_out_low(fault_out_low), .lock_detect(lock_detect), .stop_seen(stop_seen), .pin_clash(pin_clash));

	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
		end
	endtask : check

	task settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : settle

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			bad_count++;
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task pulse;
		@(posedge clk);
		fire <= 1'b1;
		@(posedge clk);
		fire <= 1'b0;
		settle(3);
	endtask : pulse

	task close_out;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : close_out

	// ---------------------------------------------------------------
	// tests
	// ---------------------------------------------------------------
	initial
	begin
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		settle(1);
		check("brake_rst", brake, 75);
		check("ref_rst", ref_pct, 70);
		check("tpa_rst", tpa_en, 0);
		check("fault_rst", fault_out_low, 1);
		apb(1'b0, MFFC_OFS_CLOSED_LOOP_TWO, 32'h0);
		check("cl2_rst", rd, 32'h0);
		apb(1'b0, MFFC_OFS_FLUX_TORQUE, 32'h0);
		check("ftc_rst", rd, 32'h0);
		apb(1'b0, MFFC_OFS_LOCK_FAULT, 32'h0);
		check("lfs_rst", rd, 32'h0);
		for (int i = 0; i < 32; i++)
		begin
			v = (32'(i) << 19) | 32'hA000_0005;
			apb(1'b1, MFFC_OFS_CLOSED_LOOP_TWO, v);
			apb(1'b0, MFFC_OFS_CLOSED_LOOP_TWO, 32'h0);
			check("cl2_rw", rd, v);
			check("brake_dec", brake, brake_tab[i]);
		end
		for (int i = 0; i < 8; i++)
		begin
			k = i[2:0];
			v = {25'h0, k[1], k[1:0], k, k[0]};
			apb(1'b1, MFFC_OFS_FLUX_TORQUE, v | 32'hFFFF_FF80);
			apb(1'b0, MFFC_OFS_FLUX_TORQUE, 32'h0);
			check("ftc_rw", rd, v);
			check("tpa_en", tpa_en, k[1]);
			check("fw_en", fw_en, k[0]);
			check("ref_dec", ref_pct, ref_tab[k[1:0]]);
			check("cap_dec", cap_pct, cap_tab[k]);
		end
		apb(1'b1, MFFC_OFS_IRQ_ENABLE, 32'h7);
		apb(1'b1, MFFC_OFS_LOCK_FAULT, 32'h0);
		pulse();
		check("m0_pin", fault_out_low, 0);
		check("m0_stop", motor_stop, 1);
		check("m0_irq", irq, 1);
		settle(600);
		check("m0_hold", fault_out_low, 0);
		apb(1'b0, MFFC_OFS_IRQ_STATUS, 32'h0);
		check("m0_stat", rd, 32'h1);
		apb(1'b1, MFFC_OFS_IRQ_CLEAR, 32'h1);
		settle(2);
		check("m0_clr", fault_out_low, 1);
		check("m0_irq_clr", irq, 0);
		for (int c = 0; c < 4; c++)
		begin
			apb(1'b1, MFFC_OFS_LOCK_FAULT, (32'(c) << 2) | 32'h1);
			pulse();
			check("m1_pin", fault_out_low, 0);
			settle(retry_ms[c] * CPM - 12);
			check("m1_early", fault_out_low, 0);
			settle(20);
			check("m1_auto", fault_out_low, 1);
			apb(1'b0, MFFC_OFS_IRQ_STATUS, 32'h0);
			check("m1_stat", rd, 32'h4);
			apb(1'b1, MFFC_OFS_IRQ_CLEAR, 32'h7);
		end
		apb(1'b1, MFFC_OFS_IRQ_ENABLE, 32'h0);
		apb(1'b1, MFFC_OFS_LOCK_FAULT, 32'h2);
		pulse();
		check("m2_pin", fault_out_low, 1);
		check("m2_stop", motor_stop, 0);
		check("m2_mask", irq, 0);
		apb(1'b0, MFFC_OFS_IRQ_STATUS, 32'h0);
		check("m2_stat", rd, 32'h2);
		apb(1'b1, MFFC_OFS_IRQ_ENABLE, 32'h2);
		settle(2);
		check("m2_irq", irq, 1);
		apb(1'b1, MFFC_OFS_IRQ_CLEAR, 32'h2);
		settle(2);
		check("m2_irq_clr", irq, 0);
		apb(1'b1, MFFC_OFS_LOCK_FAULT, 32'h3);
		pulse();
		check("m3_pin", fault_out_low, 1);
		apb(1'b0, MFFC_OFS_IRQ_STATUS, 32'h0);
		check("m3_stat", rd, 32'h0);
		apb(1'b0, 8'h70, 32'h0);
		check("bad_err", err, 1'b1);
		check("bad_data", rd, 32'h0);
		check("stop_seen", stop_seen, 1);
		check("pin_clash", pin_clash, 0);
		// latched fault, then a reset in mid-run drops it
		apb(1'b1, MFFC_OFS_LOCK_FAULT, 32'h0);
		pulse();
		check("rst_pre", fault_out_low, 0);
		@(posedge clk);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		settle(1);
		check("rst_pin", fault_out_low, 1);
		check("rst_stop", motor_stop, 0);
		apb(1'b0, MFFC_OFS_IRQ_STATUS, 32'h0);
		check("rst_stat", rd, 32'h0);
		close_out();
	end

	// hang guard, well past the longest retry run
	initial
	begin
		repeat (60000) @(posedge clk);
		bad_count++;
		close_out();
	end
endmodule : mffc_regs_bench

`default_nettype wire
